// ==== core/select_chain_pkg.sv ====
// Constants for the channel select-chain bypass block: register map, fields, resets.
// Assumes an AXI4-Lite master with 32-bit data and one aligned word per register.
//
// How it works
// - Channel offers selection through one serial select line threaded through every unit.
// - On own address with select active, seize select and block it downstream.
// - Without address recognition, pass incoming select unchanged to the downstream output.
// - Powered down, dc power failed or off line: select bypasses the capture logic; ac-low alone does not.
// - Select reaches the capture flip-flop only while on line with dc power good.
// - Hold-out keeps the captured selection in place while it is asserted.
// - Hold-out is common to all units; dropping select releases the select path at once.
// - Select leaves downstream; the returning select-in goes back to the channel.
// - Single-pulse switch is debounced by a latch, giving one single-step set per press.
// - Online-enable switch drives a latch with true and complement outputs and indicator.
// - Ac-low and dc-low sense lines are passed on as power-fail indications.
// - Recognition needs a tagged address with odd parity; even parity never matches.
// - Unit match on bus bits 7:4 and device match on bits 3:0 decide selection.
package select_chain_pkg;
  localparam logic [3:0] CTRL_OFFSET = 4'h0;
  localparam logic [3:0] STATUS_OFFSET = 4'h4;
  localparam logic [3:0] STEP_CLEAR_OFFSET = 4'h8;

  localparam int CTRL_DEV_LSB = 0;
  localparam int CTRL_UNIT_LSB = 4;
  localparam int CTRL_DEV_ANY_BIT = 8;
  localparam int CTRL_ONLINE_REQ_BIT = 9;
  localparam int CTRL_WIDTH = 10;
  localparam logic [9:0] CTRL_RESET = 10'h000;

  localparam int STAT_CAPTURE_BIT = 0;
  localparam int STAT_BYPASS_BIT = 1;
  localparam int STAT_ONLINE_BIT = 2;
  localparam int STAT_AC_LOW_BIT = 3;
  localparam int STAT_DC_LOW_BIT = 4;
  localparam int STAT_SWITCH_BIT = 5;
  localparam int STAT_STEP_BIT = 6;
  localparam int STAT_MATCH_BIT = 7;

  localparam int STEP_CLEAR_BIT = 0;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ==== core/sync_two_ff.sv ====
// Two flip-flop synchroniser for a group of independent levels.
// Assumes each bit is a slow level; no bus coherence is given across bits.
`timescale 1ns/100ps
module sync_two_ff #(
  parameter int WIDTH = 1
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_r;

  // The first stage feeds only the second stage.
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      meta_r <= '0;
      sync_out <= '0;
    end else begin
      meta_r <= async_in;
      sync_out <= meta_r;
    end
  end
endmodule

// ==== core/channel_select_chain_bypass.sv ====
// Select-chain seize and bypass logic of a channel-attached unit, with panel latches,
// power-fail sense and an AXI4-Lite register slave.
// Assumes channel, panel and supply inputs are asynchronous to sys_clk (200 MHz).
//
// Added by the designer: the AXI4-Lite register port and the address map.
`timescale 1ns/100ps
module channel_select_chain_bypass (
  input wire logic sys_clk,
  input wire logic reset_n,
  // Channel side.
  input wire logic select_out_in,
  output logic select_in_up,
  input wire logic hold_out_line,
  input wire logic [7:0] bus_out,
  input wire logic bus_out_parity,
  input wire logic address_out_tag,
  // Downstream chain side.
  output logic select_out_down,
  input wire logic select_in_return,
  // Panel and supply.
  input wire logic single_pulse_make,
  input wire logic single_pulse_break,
  input wire logic online_switch_on,
  input wire logic online_switch_off,
  input wire logic ac_power_low,
  input wire logic dc_power_low,
  output logic select_capture_ff,
  output logic single_step_ff,
  output logic online_enable_switch_state,
  output logic online_enable_switch_state_n,
  output logic online_indicator,
  output logic ac_power_fail,
  output logic dc_power_fail,
  // AXI4-Lite slave.
  input wire logic [3:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [3:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready
);

  ////////////////////////////////////////////////////////////////////////////////////////
  // Synchronisers.

  localparam int SYNC_W = 19;
  logic [SYNC_W-1:0] sync_q;
  logic sel_s, hold_s, ret_s, tag_s, par_s, sp_make_s, sp_break_s;
  logic on_s, off_s, acl_s, dcl_s;
  logic [7:0] bus_s;

  sync_two_ff #(.WIDTH(SYNC_W)) u_sync (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .async_in({select_out_in, hold_out_line, select_in_return, address_out_tag,
               bus_out_parity, bus_out, single_pulse_make, single_pulse_break,
               online_switch_on, online_switch_off, ac_power_low, dc_power_low}),
    .sync_out(sync_q)
  );

  assign {sel_s, hold_s, ret_s, tag_s, par_s, bus_s, sp_make_s, sp_break_s,
          on_s, off_s, acl_s, dcl_s} = sync_q;

  ////////////////////////////////////////////////////////////////////////////////////////
  // Registers and address recognition.

  logic [select_chain_pkg::CTRL_WIDTH-1:0] ctrl_r;
  logic [3:0] dev_addr_w, unit_addr_w;
  logic dev_any_w, online_req_w;
  logic parity_good, unit_address_match, device_number_match, full_address_match;

  assign dev_addr_w = ctrl_r[select_chain_pkg::CTRL_DEV_LSB +: 4];
  assign unit_addr_w = ctrl_r[select_chain_pkg::CTRL_UNIT_LSB +: 4];
  assign dev_any_w = ctrl_r[select_chain_pkg::CTRL_DEV_ANY_BIT];
  assign online_req_w = ctrl_r[select_chain_pkg::CTRL_ONLINE_REQ_BIT];

  // Odd parity over the eight address bits plus the parity bit.
  assign parity_good = ^{bus_s, par_s};
  assign unit_address_match = tag_s & parity_good & (bus_s[7:4] == unit_addr_w);
  assign device_number_match = dev_any_w | (bus_s[3:0] == dev_addr_w);
  assign full_address_match = unit_address_match & device_number_match;

  ////////////////////////////////////////////////////////////////////////////////////////
  // Select seize and bypass.

  logic online_en_r, online_en_nxt;
  logic online_w, bypass_w, capture_nxt;
  logic select_capture_r, sel_down_r, sel_up_r;

  assign online_w = online_en_r & online_req_w & ~dcl_s;
  assign bypass_w = ~online_w;

  // Capture only sees select while the path is live; a dropped select frees it at once,
  // so a hung hold-out can never keep the chain blocked.
  assign capture_nxt = bypass_w ? 1'b0 :
                       !sel_s ? 1'b0 :
                       (hold_s & select_capture_r) ? 1'b1 :
                       full_address_match;

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      select_capture_r <= 1'b0;
      sel_down_r <= 1'b0;
      sel_up_r <= 1'b0;
    end else begin
      select_capture_r <= capture_nxt;
      sel_down_r <= sel_s & ~capture_nxt;
      sel_up_r <= ret_s;
    end
  end

  assign select_capture_ff = select_capture_r;
  assign select_out_down = sel_down_r;
  assign select_in_up = sel_up_r;

  ////////////////////////////////////////////////////////////////////////////////////////
  // Panel latches, single step and power-fail sense.

  logic sp_latch_r, sp_latch_nxt, step_pulse_w, step_r, step_clear_w;
  logic acf_r, dcf_r, online_n_r, indicator_r;

  // Make sets and break clears; a contact bouncing on one side cannot toggle the latch.
  assign sp_latch_nxt = sp_make_s ? 1'b1 : (sp_break_s ? 1'b0 : sp_latch_r);
  assign step_pulse_w = sp_latch_nxt & ~sp_latch_r;
  assign online_en_nxt = on_s ? 1'b1 : (off_s ? 1'b0 : online_en_r);

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      sp_latch_r <= 1'b0;
      step_r <= 1'b0;
      online_en_r <= 1'b0;
      online_n_r <= 1'b1;
      indicator_r <= 1'b0;
      acf_r <= 1'b0;
      dcf_r <= 1'b0;
    end else begin
      sp_latch_r <= sp_latch_nxt;
      // A new press wins over a software clear in the same cycle.
      step_r <= step_pulse_w | (step_r & ~step_clear_w);
      online_en_r <= online_en_nxt;
      online_n_r <= ~online_en_nxt;
      indicator_r <= online_en_nxt;
      acf_r <= acl_s;
      dcf_r <= dcl_s;
    end
  end

  assign single_step_ff = step_r;
  assign online_enable_switch_state = online_en_r;
  assign online_enable_switch_state_n = online_n_r;
  assign online_indicator = indicator_r;
  assign ac_power_fail = acf_r;
  assign dc_power_fail = dcf_r;

  ////////////////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite slave: one write and one read at a time; read answers in the cycle after acceptance, write one cycle later.

  logic awready_r, wready_r, bvalid_r, arready_r, rvalid_r;
  logic [3:0] waddr_r;
  logic [31:0] wdata_r, rdata_r, rd_word_w;
  logic [3:0] wstrb_r;
  logic [1:0] bresp_r, rresp_r;
  logic aw_hs, w_hs, ar_hs, do_write, wr_ctrl, wr_known, rd_known;

  assign aw_hs = awvalid & awready_r;
  assign w_hs = wvalid & wready_r;
  assign ar_hs = arvalid & arready_r;
  assign do_write = ~awready_r & ~wready_r & ~bvalid_r;
  assign wr_ctrl = do_write & (waddr_r == select_chain_pkg::CTRL_OFFSET);
  assign step_clear_w = do_write & (waddr_r == select_chain_pkg::STEP_CLEAR_OFFSET) &
                        wstrb_r[0] & wdata_r[select_chain_pkg::STEP_CLEAR_BIT];
  assign wr_known = (waddr_r == select_chain_pkg::CTRL_OFFSET) |
                    (waddr_r == select_chain_pkg::STEP_CLEAR_OFFSET);
  assign rd_known = (araddr == select_chain_pkg::CTRL_OFFSET) |
                    (araddr == select_chain_pkg::STATUS_OFFSET) |
                    (araddr == select_chain_pkg::STEP_CLEAR_OFFSET);

  always_comb begin
    rd_word_w = 32'h0000_0000;
    if (araddr == select_chain_pkg::CTRL_OFFSET) begin
      rd_word_w[select_chain_pkg::CTRL_WIDTH-1:0] = ctrl_r;
    end else if (araddr == select_chain_pkg::STATUS_OFFSET) begin
      rd_word_w[select_chain_pkg::STAT_CAPTURE_BIT] = select_capture_r;
      rd_word_w[select_chain_pkg::STAT_BYPASS_BIT] = bypass_w;
      rd_word_w[select_chain_pkg::STAT_ONLINE_BIT] = online_w;
      rd_word_w[select_chain_pkg::STAT_AC_LOW_BIT] = acl_s;
      rd_word_w[select_chain_pkg::STAT_DC_LOW_BIT] = dcl_s;
      rd_word_w[select_chain_pkg::STAT_SWITCH_BIT] = online_en_r;
      rd_word_w[select_chain_pkg::STAT_STEP_BIT] = step_r;
      rd_word_w[select_chain_pkg::STAT_MATCH_BIT] = full_address_match;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      awready_r <= 1'b1;
      wready_r <= 1'b1;
      bvalid_r <= 1'b0;
      bresp_r <= select_chain_pkg::RESP_OKAY;
      waddr_r <= 4'h0;
      wdata_r <= 32'h0000_0000;
      wstrb_r <= 4'h0;
    end else begin
      if (aw_hs) begin
        awready_r <= 1'b0;
        waddr_r <= awaddr;
      end
      if (w_hs) begin
        wready_r <= 1'b0;
        wdata_r <= wdata;
        wstrb_r <= wstrb;
      end
      if (do_write) begin
        bvalid_r <= 1'b1;
        bresp_r <= wr_known ? select_chain_pkg::RESP_OKAY : select_chain_pkg::RESP_SLVERR;
      end else if (bvalid_r & bready) begin
        bvalid_r <= 1'b0;
        awready_r <= 1'b1;
        wready_r <= 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_r <= select_chain_pkg::CTRL_RESET;
    end else if (wr_ctrl) begin
      if (wstrb_r[0]) begin
        ctrl_r[7:0] <= wdata_r[7:0];
      end
      if (wstrb_r[1]) begin
        ctrl_r[select_chain_pkg::CTRL_WIDTH-1:8] <= wdata_r[select_chain_pkg::CTRL_WIDTH-1:8];
      end
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      arready_r <= 1'b1;
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      rresp_r <= select_chain_pkg::RESP_OKAY;
    end else if (ar_hs) begin
      arready_r <= 1'b0;
      rvalid_r <= 1'b1;
      rdata_r <= rd_word_w;
      rresp_r <= rd_known ? select_chain_pkg::RESP_OKAY : select_chain_pkg::RESP_SLVERR;
    end else if (rvalid_r & rready) begin
      rvalid_r <= 1'b0;
      arready_r <= 1'b1;
    end
  end

  assign awready = awready_r;
  assign wready = wready_r;
  assign bvalid = bvalid_r;
  assign bresp = bresp_r;
  assign arready = arready_r;
  assign rvalid = rvalid_r;
  assign rdata = rdata_r;
  assign rresp = rresp_r;

  ////////////////////////////////////////////////////////////////////////////////////////
  // Assertions.

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  a_bypass_no_capture: assert property (bypass_w |=> !select_capture_r)
    else $error("capture set while bypassed");
  a_capture_needs_online: assert property (
    $rose(select_capture_r) |-> $past(online_w && sel_s && full_address_match))
    else $error("capture without live path and match");
  a_seize_blocks_down: assert property (select_capture_r |-> !sel_down_r)
    else $error("select forwarded while seized");
  a_forward_unmatched: assert property (
    (sel_s && !full_address_match && !select_capture_r) |=> sel_down_r)
    else $error("unmatched select not forwarded");
  a_hold_keeps_seize: assert property (
    (select_capture_r && hold_s && sel_s && online_w) |=> select_capture_r)
    else $error("capture lost under hold-out");
  a_drop_releases: assert property (!sel_s |=> !select_capture_r && !sel_down_r)
    else $error("select path kept after drop");
  a_return_to_channel: assert property (##1 sel_up_r == $past(ret_s))
    else $error("select-in not returned");
  a_even_parity_blind: assert property (!parity_good |-> !full_address_match)
    else $error("even parity address recognised");
  a_step_per_press: assert property (step_pulse_w |=> step_r)
    else $error("single step not set by press");
  a_online_pair: assert property (online_en_r != online_n_r)
    else $error("online latch outputs not complementary");
  a_power_fail_sense: assert property (
    ##1 dcf_r == $past(dcl_s) && acf_r == $past(acl_s))
    else $error("power-fail sense not passed on");
endmodule

// ==== testbench/downstream_chain.sv ====
// Model of the control units further down the select chain.
// Assumes the last unit carries the return jumper and no other unit is powered off.
`timescale 1ns/100ps
module downstream_chain #(
  parameter int DELAY = 2
) (
  input wire logic sys_clk,
  input wire logic select_out_down,
  input wire logic claim,
  output logic select_in_return
);
  logic [DELAY:0] pipe_r = '0;

  // A claiming unit swallows select; otherwise it comes back late, as a long cable would.
  always_ff @(posedge sys_clk) begin
    pipe_r <= {pipe_r[DELAY-1:0], select_out_down & ~claim};
  end
  assign select_in_return = pipe_r[DELAY];
endmodule

// ==== testbench/test_channel_select_chain_bypass.sv ====
// Self-checking bench for the select-chain bypass block with a downstream chain model.
// Assumes the design answers AXI4-Lite by itself and settles inputs within three edges.
`timescale 1ns/100ps
module test_channel_select_chain_bypass;
  logic sys_clk = 1'h0;
  logic reset_n = 1'h0;
  logic select_out_in = 1'h0, hold_out_line = 1'h0, bus_out_parity = 1'h0;
  logic address_out_tag = 1'h0, select_in_return, claim = 1'h0;
  logic [7:0] bus_out = 8'h00;
  logic single_pulse_make = 1'h0, single_pulse_break = 1'h1, online_switch_on = 1'h0;
  logic online_switch_off = 1'h1, ac_power_low = 1'h0, dc_power_low = 1'h0;
  logic select_in_up, select_out_down, select_capture_ff, single_step_ff;
  logic online_enable_switch_state, online_enable_switch_state_n, online_indicator;
  logic ac_power_fail, dc_power_fail, awready, wready, bvalid, arready, rvalid;
  logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  logic [3:0] awaddr = 4'h0, araddr = 4'h0, wstrb = 4'h0, unit, dev;
  logic [31:0] wdata = 32'h0, rdata, d;
  logic [1:0] bresp, rresp, r;
  logic onl, e, ta, tw, bv, dany;
  integer seed, i, err_count = 0, cmp_count = 0;

  always #2.5 sys_clk = ~sys_clk;

  channel_select_chain_bypass u_channel_select_chain_bypass (
    .sys_clk(sys_clk), .reset_n(reset_n), .select_out_in(select_out_in),
    .select_in_up(select_in_up), .hold_out_line(hold_out_line), .bus_out(bus_out),
    .bus_out_parity(bus_out_parity), .address_out_tag(address_out_tag),
    .select_out_down(select_out_down), .select_in_return(select_in_return),
    .single_pulse_make(single_pulse_make), .single_pulse_break(single_pulse_break),
    .online_switch_on(online_switch_on), .online_switch_off(online_switch_off),
    .ac_power_low(ac_power_low), .dc_power_low(dc_power_low),
    .select_capture_ff(select_capture_ff), .single_step_ff(single_step_ff),
    .online_enable_switch_state(online_enable_switch_state),
    .online_enable_switch_state_n(online_enable_switch_state_n),
    .online_indicator(online_indicator), .ac_power_fail(ac_power_fail),
    .dc_power_fail(dc_power_fail), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready)
  );

  downstream_chain u_downstream_chain (
    .sys_clk(sys_clk), .select_out_down(select_out_down), .claim(claim),
    .select_in_return(select_in_return)
  );

  ////////////////////////////////////////////////////////////////////////////////////////
  task step(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  task chk(input logic [31:0] g, input logic [31:0] x);
    cmp_count++;
    if (g !== x) begin
      err_count++;
      $display("unexpected at %0t: got %h expected %h", $time, g, x);
    end
  endtask

  task chkb(input logic g, input logic x);
    chk({31'h0, g}, {31'h0, x});
  endtask

  task results;
    if (err_count == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // Ready and valid are sampled at the falling edge, where the registered outputs are
  // settled, and the request is released at the following rising edge.
  task wr(input logic [3:0] a, input logic [31:0] v);
    step(1);
    {awaddr, wdata, wstrb} <= {a, v, 4'hf};
    {awvalid, wvalid, bready} <= 3'h7;
    do begin
      @(negedge sys_clk);
      {ta, tw, bv, r} = {awready, wready, bvalid, bresp};
      @(posedge sys_clk);
      if (ta) awvalid <= 1'h0;
      if (tw) wvalid <= 1'h0;
    end while (!bv);
    bready <= 1'h0;
  endtask

  task rd(input logic [3:0] a);
    step(1);
    araddr <= a;
    {arvalid, rready} <= 2'h3;
    do begin
      @(negedge sys_clk);
      {ta, tw, d, r} = {arready, rvalid, rdata, rresp};
      @(posedge sys_clk);
      if (ta) arvalid <= 1'h0;
    end while (!tw);
    rready <= 1'h0;
  endtask

  // One selection attempt: offer, hold with the address withdrawn, then drop select.
  task sel_try(input logic [7:0] b, input logic p, input logic t);
    e = t & (^{b, p}) & (b[7:4] == unit) & (dany | (b[3:0] == dev)) & onl;
    step(1);
    {bus_out, bus_out_parity, address_out_tag, select_out_in} <= {b, p, t, 1'h1};
    step(10);
    @(negedge sys_clk);
    chkb(select_capture_ff, e);
    chkb(select_out_down, !e);
    chkb(select_in_up, !e & !claim);
    step(1);
    hold_out_line <= 1'h1;
    step(4);
    address_out_tag <= 1'h0;
    step(4);
    @(negedge sys_clk);
    chkb(select_capture_ff, e);
    step(1);
    select_out_in <= 1'h0;
    step(4);
    @(negedge sys_clk);
    chkb(select_capture_ff, 1'h0);
    chkb(select_out_down, 1'h0);
    step(1);
    hold_out_line <= 1'h0;
  endtask

  ////////////////////////////////////////////////////////////////////////////////////////
  initial begin
    seed = 28622;
    onl = 1'h0;
    dany = 1'h0;
    step(12);
    reset_n <= 1'h1;
    @(negedge sys_clk);
    chkb(select_capture_ff, 1'h0);
    chkb(online_enable_switch_state_n, 1'h1);
    rd(select_chain_pkg::CTRL_OFFSET);
    chk(d, 32'h0);
    rd(4'hc);
    chk({30'h0, r}, {30'h0, select_chain_pkg::RESP_SLVERR});
    chk(d, 32'h0000_0000);
    wr(4'hc, 32'hffff_ffff);
    chk({30'h0, r}, {30'h0, select_chain_pkg::RESP_SLVERR});
    {unit, dev} = 8'($random(seed));
    step(1);
    {online_switch_off, online_switch_on} <= 2'h1;
    step(2);
    online_switch_on <= 1'h0;
    wr(select_chain_pkg::CTRL_OFFSET, {22'h0, 2'h2, unit, dev});
    @(negedge sys_clk);
    chkb(online_enable_switch_state, 1'h1);
    chkb(online_enable_switch_state_n, 1'h0);
    chkb(online_indicator, 1'h1);
    rd(select_chain_pkg::CTRL_OFFSET);
    chk(d, {22'h0, 2'h2, unit, dev});
    onl = 1'h1;
    sel_try({unit, dev}, ^{unit, dev}, 1'h1);
    sel_try({unit, dev}, ~^{unit, dev}, 1'h1);
    sel_try({~unit, dev}, ~^{unit, dev}, 1'h1);
    for (i = 0; i < 40; i++) begin
      claim <= 1'($random(seed));
      sel_try(i[0] ? {unit, dev} : 8'($random(seed)), 1'($random(seed)), (i % 3) != 0);
    end
    // Device digit ignored: any device number under the own unit address is seized.
    wr(select_chain_pkg::CTRL_OFFSET, {22'h0, 2'h3, unit, dev});
    chk({30'h0, r}, {30'h0, select_chain_pkg::RESP_OKAY});
    dany = 1'h1;
    sel_try({unit, ~dev}, ~^{unit, dev}, 1'h1);
    wr(select_chain_pkg::CTRL_OFFSET, {22'h0, 2'h2, unit, dev});
    chk({30'h0, r}, {30'h0, select_chain_pkg::RESP_OKAY});
    dany = 1'h0;
    // Off line through the panel switch, then back on line.
    step(1);
    online_switch_off <= 1'h1;
    onl = 1'h0;
    sel_try({unit, dev}, ~^{unit, dev}, 1'h1);
    step(1);
    {online_switch_off, online_switch_on} <= 2'h1;
    step(2);
    online_switch_on <= 1'h0;
    // Power failing with the unit otherwise on line; ac first, so a swapped pair shows.
    ac_power_low <= 1'h1;
    step(4);
    @(negedge sys_clk);
    chkb(ac_power_fail, 1'h1);
    chkb(dc_power_fail, 1'h0);
    step(1);
    dc_power_low <= 1'h1;
    sel_try({unit, dev}, ~^{unit, dev}, 1'h1);
    @(negedge sys_clk);
    chkb(dc_power_fail, 1'h1);
    chkb(ac_power_fail, 1'h1);
    rd(select_chain_pkg::STATUS_OFFSET);
    chk(d, 32'h0000_003a);
    step(1);
    {single_pulse_make, single_pulse_break} <= 2'h2;
    step(4);
    @(negedge sys_clk);
    chkb(single_step_ff, 1'h1);
    step(1);
    {single_pulse_make, single_pulse_break} <= 2'h1;
    step(4);
    wr(select_chain_pkg::STEP_CLEAR_OFFSET, 32'h1);
    @(negedge sys_clk);
    chkb(single_step_ff, 1'h0);
    results;
  end

  initial begin
    step(6000);
    err_count++;
    results;
  end
endmodule
